// File: tpio_regs.svh
// Offsets, field positions, reset values and timing figures of the terminal I/O control block.
// Assumes a 40 MHz core clock and a 32-bit APB register bus.
`ifndef TPIO_REGS_SVH
`define TPIO_REGS_SVH
`define TPIO_CLK_HZ 40000000
`define TPIO_CLK_MHZ 40
`define TPIO_TAPE_BAUD 2400
`define TPIO_SLOW_BAUD 300
`define TPIO_PRN_CPS 30
`define TPIO_STB_NS 1000
`define TPIO_STB_CYC ((`TPIO_STB_NS * `TPIO_CLK_MHZ + 999) / 1000)
`define TPIO_A_CTRL 8'h00
`define TPIO_A_BAUD 8'h04
`define TPIO_A_XFER 8'h08
`define TPIO_A_STAT 8'h0c
`define TPIO_A_CUR 8'h10
`define TPIO_GO_SEND 8
`define TPIO_GO_PRN 9
`define TPIO_GO_REC 10
`define TPIO_XFER_LEN 16
`define TPIO_ST_PERR 0
`define TPIO_CTRL_RST 8'h00
`define TPIO_BAUD_RST 20'h01046
`define TPIO_ROW_LEN 11'h04a
`define TPIO_COL_LAST 7'h49
`define TPIO_CMD_CUR 7'h11
`define TPIO_CMD_MAX 7'h1f
`endif

// File: tpio_pkg.sv
// Types shared by the terminal I/O control block.
// Assumes tpio_regs.svh for the numeric constants.
package tpio_pkg;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000, S_READ = 3'b001, S_WAIT = 3'b010, S_LOAD = 3'b011,
        S_SHIFT = 3'b100, S_PSTB = 3'b101, S_PWAIT = 3'b110, S_NEXT = 3'b111
    } tpio_seq_type;
    typedef enum logic [1:0] {J_SEND = 2'b00, J_PRN = 2'b01, J_REC = 2'b10} tpio_job_type;
    typedef enum logic [1:0] {
        TWO_WAY_SIMULTANEOUS = 2'b00, TWO_WAY_ALTERNATE = 2'b01, BATCH = 2'b10
    } tpio_mode_type;
    typedef struct packed {
        logic          cont;
        logic          online;
        logic          chr;
        logic          page;
        logic          tclk;
        logic          odd;
        tpio_mode_type mode;
    } tpio_ctrl_type;
    typedef struct packed {
        logic        we;
        logic        re;
        logic [10:0] addr;
        logic [6:0]  data;
    } tpio_mem_type;
endpackage : tpio_pkg

// File: tpio_top.sv
// Terminal I/O control: host serial link, printer, cassette and host command decode.
// Assumes a synchronous character memory whose read data is valid the cycle after re.
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "tpio_regs.svh"
module tpio_top
    import tpio_pkg::*;
#(
    parameter int TAPE_DIV = `TPIO_CLK_HZ / `TPIO_TAPE_BAUD,
    parameter int SLOW_DIV = `TPIO_CLK_HZ / `TPIO_SLOW_BAUD,
    parameter int PACE_CYC = `TPIO_CLK_HZ / `TPIO_PRN_CPS
) (
    input  wire logic         core_clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic         psel_i,
    input  wire logic         penable_i,
    input  wire logic         pwrite_i,
    input  wire logic [7:0]   paddr_i,
    input  wire logic [31:0]  pwdata_i,
    output logic      [31:0]  prdata_o,
    output logic              pready_o,
    output logic              pslverr_o,
    input  wire logic [6:0]   kb_char_i,
    input  wire logic         kb_strobe_i,
    output tpio_mem_type      mem_o,
    input  wire logic [6:0]   mem_rdata_i,
    output logic              entry_trig_o,
    output logic      [4:0]   entry_cmd_o,
    output logic      [6:0]   cursor_x_o,
    output logic      [4:0]   cursor_y_o,
    input  wire logic         host_rxd_i,
    output logic              host_txd_o,
    output logic      [6:0]   prn_data_o,
    output logic              prn_strobe_o,
    input  wire logic         prn_busy_i,
    output logic              cas_data_o,
    output logic              cas_clk_o,
    input  wire logic         cas_clk_i,
    input  wire logic         cas_data_i,
    input  wire logic         cas_last_i,
    output logic              cas_next_o
);
    localparam logic [5:0] STB_CYC = 6'(`TPIO_STB_CYC);

    tpio_ctrl_type ctrl_r;
    tpio_seq_type  seq_r, seq_nxt;
    tpio_job_type  job_r;
    tpio_mem_type  mem_r;
    logic [4:0]  sm_r, ss_r;
    logic        cclk_d_r, pready_r, pslverr_r, perr_r, auto_r;
    logic [31:0] prdata_r;
    logic [19:0] baud_r, bcnt_r, rx_tmr_r;
    logic [10:0] xs_r, xl_r, ptr_r, left_r, pg_cnt_r;
    logic [6:0]  kb_hold_r, tx_ch_r, rdat_r, cx_r, prn_r;
    logic        kb_full_r, tx_pend_r, rv_r, stb_r, htx_r, cdo_r, cclk_r, cnext_r;
    logic [9:0]  tx_sh_r;
    logic [3:0]  tx_cnt_r, rx_cnt_r;
    logic        rx_act_r;
    logic [7:0]  rx_sh_r;
    logic [1:0]  cur_st_r;
    logic [4:0]  cy_r, cmd_r;
    logic        trig_r;
    logic [5:0]  stb_cnt_r;
    logic [20:0] pace_r;

    // Outside pins pass two flip-flops: {last, busy, tape clock, tape data, host rx}.
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            sm_r <= 5'h0b;
            ss_r <= 5'h0b;
            cclk_d_r <= 1'b0;
        end else begin
            sm_r <= {cas_last_i, prn_busy_i, cas_clk_i, cas_data_i, host_rxd_i};
            ss_r <= sm_r;
            cclk_d_r <= ss_r[2];
        end
    end
    wire host_s = ss_r[0];
    wire cdat_s = ss_r[1];
    wire cedge  = ss_r[2] & ~cclk_d_r;
    wire busy_s = ss_r[3];
    wire last_s = ss_r[4];

    // APB slave: one wait state, writes act at the edge that samples pready.
    wire acc    = psel_i & penable_i;
    wire wr_en  = acc & pready_r & pwrite_i;
    wire a_ctrl = paddr_i == `TPIO_A_CTRL;
    wire a_baud = paddr_i == `TPIO_A_BAUD;
    wire a_xfer = paddr_i == `TPIO_A_XFER;
    wire a_stat = paddr_i == `TPIO_A_STAT;
    wire a_cur  = paddr_i == `TPIO_A_CUR;
    wire hit    = a_ctrl | a_baud | a_xfer | a_stat | a_cur;
    wire tx_busy = tx_pend_r | (tx_cnt_r != 4'h0);
    wire [31:0] stat_w = {16'h0, 1'b0, rx_sh_r[6:0], 1'b0, seq_r, 1'b0, rx_act_r, tx_busy, perr_r};
    wire [31:0] rd_mux = a_ctrl ? {24'h0, ctrl_r} : a_baud ? {12'h0, baud_r} :
                         a_xfer ? {5'h0, xl_r, 5'h0, xs_r} : a_stat ? stat_w :
                         a_cur ? {19'h0, cy_r, 1'b0, cx_r} : 32'h0;
    wire go_send = wr_en & a_ctrl & pwdata_i[`TPIO_GO_SEND];
    wire go_prn  = wr_en & a_ctrl & pwdata_i[`TPIO_GO_PRN];
    wire go_rec  = wr_en & a_ctrl & pwdata_i[`TPIO_GO_REC];

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end else begin
            pready_r  <= acc & ~pready_r;
            pslverr_r <= acc & ~pready_r & ~hit;
            prdata_r  <= (acc & ~pready_r & ~pwrite_i) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ctrl_r <= tpio_ctrl_type'(`TPIO_CTRL_RST);
            baud_r <= `TPIO_BAUD_RST;
            xs_r   <= 11'h0;
            xl_r   <= 11'h0;
        end else if (wr_en) begin
            if (a_ctrl) ctrl_r <= tpio_ctrl_type'(pwdata_i[7:0]);
            if (a_baud) baud_r <= (pwdata_i[19:0] < 20'h2) ? 20'h2 : pwdata_i[19:0];
            if (a_xfer) xs_r <= pwdata_i[10:0];
            if (a_xfer) xl_r <= pwdata_i[`TPIO_XFER_LEN+10:`TPIO_XFER_LEN];
        end
    end

    // Baud divider; the shift clock is low in the first half of each bit.
    wire btick = bcnt_r == 20'h0;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i | btick) bcnt_r <= baud_r - 20'h1;
        else bcnt_r <= bcnt_r - 20'h1;
    end

    // Transmit path with a keyboard holding buffer and a one-character pending buffer.
    wire rec_act  = (job_r == J_REC) && (seq_r != S_IDLE);
    wire tx_tick  = (rec_act && ctrl_r.tclk) ? cedge : btick;
    wire tx_idle  = ~tx_busy;
    wire kb_ok    = kb_strobe_i && (ctrl_r.mode != BATCH);
    wire kb_take  = kb_full_r && (seq_r == S_IDLE) && tx_idle;
    wire seq_take = (seq_r == S_LOAD) && (job_r != J_PRN) && tx_idle;
    wire tx_start = tx_tick && tx_pend_r && (tx_cnt_r == 4'h0);
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            kb_full_r <= 1'b0;
            kb_hold_r <= 7'h0;
        end else if (kb_ok) begin
            kb_full_r <= 1'b1;
            kb_hold_r <= kb_char_i;
        end else if (kb_take) begin
            kb_full_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            tx_pend_r <= 1'b0;
            tx_ch_r   <= 7'h0;
        end else if (kb_take | seq_take) begin
            tx_pend_r <= 1'b1;
            tx_ch_r   <= kb_take ? kb_hold_r : rdat_r;
        end else if (tx_start) begin
            tx_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            tx_sh_r  <= 10'h3ff;
            tx_cnt_r <= 4'h0;
        end else if (tx_start) begin
            tx_sh_r  <= {1'b1, ^tx_ch_r ^ ctrl_r.odd, tx_ch_r, 1'b0};
            tx_cnt_r <= 4'ha;
        end else if (tx_tick && tx_cnt_r != 4'h0) begin
            tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
            tx_cnt_r <= tx_cnt_r - 4'h1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            htx_r  <= 1'b1;
            cdo_r  <= 1'b1;
            cclk_r <= 1'b0;
        end else begin
            htx_r  <= ctrl_r.chr ? cdat_s : (rec_act | tx_sh_r[0]);
            cdo_r  <= rec_act ? tx_sh_r[0] : 1'b1;
            cclk_r <= bcnt_r < {1'b0, baud_r[19:1]};
        end
    end

    // Receiver: host line, or cassette data in page and character playback.
    wire        rx_in  = (ctrl_r.page | ctrl_r.chr) ? cdat_s : host_s;
    wire [19:0] rx_div = ctrl_r.page ? 20'(TAPE_DIV) : baud_r;
    wire        rx_smp = rx_act_r && (rx_tmr_r == 20'h0);
    wire        rx_ok  = rx_smp && (rx_cnt_r == 4'h9) && rx_in;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rx_act_r <= 1'b0;
            rx_cnt_r <= 4'h0;
            rx_tmr_r <= 20'h0;
        end else if (!rx_act_r && !rx_in) begin
            rx_act_r <= 1'b1;
            rx_cnt_r <= 4'h0;
            rx_tmr_r <= {1'b0, rx_div[19:1]};
        end else if (rx_smp) begin
            rx_act_r <= !(rx_cnt_r == 4'h9 || (rx_cnt_r == 4'h0 && rx_in));
            rx_cnt_r <= rx_cnt_r + 4'h1;
            rx_tmr_r <= rx_div - 20'h1;
        end else if (rx_act_r) begin
            rx_tmr_r <= rx_tmr_r - 20'h1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) rx_sh_r <= 8'h0;
        else if (rx_smp && rx_cnt_r != 4'h0 && rx_cnt_r != 4'h9) rx_sh_r <= {rx_in, rx_sh_r[7:1]};
    end

    wire rx_bad = rx_ok && (^rx_sh_r ^ ctrl_r.odd);
    wire perr_clr = wr_en && a_stat && pwdata_i[`TPIO_ST_PERR];
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) perr_r <= 1'b0;
        else perr_r <= rx_bad | (perr_r & ~perr_clr);
    end

    // Entry decode: cursor command, control codes, printable characters.
    wire [6:0]  rch      = rx_sh_r[6:0];
    wire        rx_use   = rx_ok && !ctrl_r.page && (!ctrl_r.chr || ctrl_r.mode == TWO_WAY_ALTERNATE);
    wire        cur_cmd  = rx_use && cur_st_r == 2'h0 && rch == `TPIO_CMD_CUR;
    wire        ctl_cmd  = rx_use && cur_st_r == 2'h0 && rch <= `TPIO_CMD_MAX && !cur_cmd;
    wire        prt_wr   = rx_use && cur_st_r == 2'h0 && rch > `TPIO_CMD_MAX;
    wire        pg_wr    = rx_ok && ctrl_r.page;
    wire        wr_now   = prt_wr | pg_wr;
    wire [10:0] cur_addr = 11'(cy_r) * `TPIO_ROW_LEN + 11'(cx_r);
    wire        blk_end  = pg_wr && (pg_cnt_r + 11'h1 >= xl_r);
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cur_st_r <= 2'h0;
            cx_r     <= 7'h0;
            cy_r     <= 5'h0;
        end else if (rx_use && cur_st_r == 2'h1) begin
            cur_st_r <= 2'h2;
            cx_r     <= rch;
        end else if (rx_use && cur_st_r == 2'h2) begin
            cur_st_r <= 2'h0;
            cy_r     <= rch[4:0];
        end else if (cur_cmd) begin
            cur_st_r <= 2'h1;
        end else if (prt_wr) begin
            cx_r <= (cx_r == `TPIO_COL_LAST) ? 7'h0 : cx_r + 7'h1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            trig_r <= 1'b0;
            cmd_r  <= 5'h0;
        end else begin
            trig_r <= prt_wr | ctl_cmd | (rx_use && cur_st_r == 2'h2) | pg_wr;
            cmd_r  <= ctl_cmd ? rch[4:0] : (rx_use && cur_st_r == 2'h2) ? 5'(`TPIO_CMD_CUR) : 5'h0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) pg_cnt_r <= 11'h0;
        else if (pg_wr) pg_cnt_r <= blk_end ? 11'h0 : pg_cnt_r + 11'h1;
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) mem_r <= '0;
        else mem_r <= '{we: wr_now, re: (seq_r == S_READ) && !wr_now,
                        addr: pg_wr ? xs_r + pg_cnt_r : wr_now ? cur_addr : ptr_r,
                        data: rch};
    end

    // Readout sequencer for block send, printing and recording.
    wire auto_go = blk_end && ctrl_r.online;
    wire start   = (go_send | go_prn | go_rec | auto_go) && (xl_r != 11'h0);
    wire fast    = baud_r < 20'(SLOW_DIV);
    wire last_ch = left_r == 11'h1;
    always_comb begin
        seq_nxt = seq_r;
        unique case (seq_r)
            S_IDLE:  if (start) seq_nxt = S_READ;
            S_READ:  if (!wr_now) seq_nxt = S_WAIT;
            S_WAIT:  if (rv_r) seq_nxt = S_LOAD;
            S_LOAD:  if (job_r == J_PRN) seq_nxt = S_PSTB;
                     else if (tx_idle) seq_nxt = S_SHIFT;
            S_SHIFT: if (tx_idle) seq_nxt = S_NEXT;
            S_PSTB:  if (stb_cnt_r == 6'h1) seq_nxt = S_PWAIT;
            S_PWAIT: if (!busy_s && pace_r == 21'h0) seq_nxt = S_NEXT;
            S_NEXT:  seq_nxt = last_ch ? S_IDLE : S_READ;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) seq_r <= S_IDLE;
        else seq_r <= seq_nxt;
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            job_r  <= J_SEND;
            auto_r <= 1'b0;
            ptr_r  <= 11'h0;
            left_r <= 11'h0;
        end else if (seq_r == S_IDLE && start) begin
            job_r  <= go_prn ? J_PRN : go_rec ? J_REC : J_SEND;
            auto_r <= auto_go && !(go_prn | go_rec | go_send);
            ptr_r  <= xs_r;
            left_r <= xl_r;
        end else if (seq_r == S_NEXT) begin
            ptr_r  <= ptr_r + 11'h1;
            left_r <= left_r - 11'h1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rv_r   <= 1'b0;
            rdat_r <= 7'h0;
        end else begin
            rv_r <= mem_r.re;
            if (rv_r) rdat_r <= mem_rdata_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            prn_r     <= 7'h0;
            stb_r     <= 1'b0;
            stb_cnt_r <= 6'h0;
        end else begin
            if (seq_r == S_LOAD && job_r == J_PRN) prn_r <= rdat_r;
            stb_r     <= seq_r == S_PSTB;
            stb_cnt_r <= (seq_r == S_PSTB) ? stb_cnt_r - 6'h1 : STB_CYC;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) pace_r <= 21'h0;
        else if (seq_r == S_LOAD && job_r == J_PRN) pace_r <= fast ? 21'(PACE_CYC - 1) : 21'h0;
        else if (pace_r != 21'h0) pace_r <= pace_r - 21'h1;
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) cnext_r <= 1'b0;
        else cnext_r <= seq_r == S_NEXT && last_ch && job_r == J_SEND && auto_r && ctrl_r.cont && !last_s;
    end

    assign prdata_o     = prdata_r;
    assign pready_o     = pready_r;
    assign pslverr_o    = pslverr_r;
    assign mem_o        = mem_r;
    assign entry_trig_o = trig_r;
    assign entry_cmd_o  = cmd_r;
    assign cursor_x_o   = cx_r;
    assign cursor_y_o   = cy_r;
    assign host_txd_o   = htx_r;
    assign prn_data_o   = prn_r;
    assign prn_strobe_o = stb_r;
    assign cas_data_o   = cdo_r;
    assign cas_clk_o    = cclk_r;
    assign cas_next_o   = cnext_r;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence strobe_on_s;
        $rose(prn_strobe_o) ##0 $stable(prn_data_o);
    endsequence
    sequence strobe_hold_s;
        prn_strobe_o [*8] ##0 $stable(prn_data_o);
    endsequence
    kb_forward_a: assert property (kb_take |=> tx_pend_r && tx_ch_r == $past(kb_hold_r))
        else $error("keyboard character not forwarded");
    blk_read_a: assert property (seq_r == S_READ && !wr_now |=> mem_o.re ##1 !mem_o.re)
        else $error("memory read not issued once");
    tx_start_a: assert property (tx_start |=> tx_cnt_r == 4'ha ##1 !host_txd_o || ctrl_r.chr || rec_act)
        else $error("start bit missing");
    prn_strobe_a: assert property (strobe_on_s |-> strobe_hold_s)
        else $error("printer strobe too short or data moved");
    prn_wait_a: assert property (seq_r == S_PWAIT && busy_s |=> seq_r != S_NEXT)
        else $error("printer advanced while busy");
    prn_pace_a: assert property (seq_r == S_LOAD && job_r == J_PRN && fast |=> pace_r == 21'(PACE_CYC - 1))
        else $error("print pacing not started");
    cursor_load_a: assert property (rx_use && cur_st_r == 2'h2
                                    |=> cursor_y_o == $past(rch[4:0]) && entry_cmd_o == 5'(`TPIO_CMD_CUR))
        else $error("cursor position not loaded");
    entry_trig_a: assert property (prt_wr |=> entry_trig_o && mem_o.we && mem_o.addr == $past(cur_addr))
        else $error("entry trigger missing for write");
    parity_err_a: assert property (rx_bad |=> perr_r [*2])
        else $error("parity error flag not held");
endmodule : tpio_top

// File: tpio_partner.sv
// Far-side model: a printer answering the strobe with busy, and a cassette tape clock.
// Assumes it shares the core clock of the terminal I/O block.
`timescale 1ns/1ps
module tpio_partner (
    input  wire logic clk_i,
    input  wire logic stb_i,
    input  wire logic run_i,
    output logic      busy_o,
    output logic      tclk_o
);
    int   hold  = 0;
    logic stb_q = 1'b0;
    initial busy_o = 1'b0;
    initial tclk_o = 1'b0;
    // Busy rises a few cycles after the strobe and holds well past the strobe's end.
    always @(posedge clk_i) begin
        stb_q <= stb_i;
        hold <= (stb_i && !stb_q) ? 253 : (hold > 0 ? hold - 1 : 0);
        busy_o <= hold > 0 && hold <= 250;
    end
    // Tape clock of 200 ns period, running only while a recording is under way.
    initial begin
        #37;
        forever #100 tclk_o = run_i ? ~tclk_o : 1'b0;
    end
endmodule : tpio_partner

// File: tpio_top_tb.sv
// Self-checking bench for the terminal I/O control block.
// Assumes tpio_partner for the printer and tape clock; the memory is modelled here.
`timescale 1ns/1ps
`include "tpio_regs.svh"
module tpio_top_tb
    import tpio_pkg::*;
;
    localparam int BD = 8;
    logic         clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, kb_stb = 1'b0;
    logic         rxd = 1'b1, run = 1'b0, sel = 1'b0, busy, tclk, pready, pslverr, err, trig, txd, pstb, cas_d;
    logic         cdi = 1'b1;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0, prdata, rd, seed = 32'hf00f2d8e;
    logic [6:0]   kb_char = 7'h00, mrd = 7'h00, pdat, cx, wd, c;
    logic [4:0]   cmd, cy, tcmd;
    logic [10:0]  wa;
    tpio_mem_type mem;
    int           mismatches = 0, n_checks = 0, cyc = 0, ntrig = 0, last, k, n0, bw = BD;
    wire          ln = sel ? cas_d : txd;

    tpio_top #(.TAPE_DIV(20), .SLOW_DIV(40), .PACE_CYC(200)) dut (
        .core_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .kb_char_i(kb_char), .kb_strobe_i(kb_stb), .mem_o(mem), .mem_rdata_i(mrd), .entry_trig_o(trig),
        .entry_cmd_o(cmd), .cursor_x_o(cx), .cursor_y_o(cy), .host_rxd_i(rxd), .host_txd_o(txd),
        .prn_data_o(pdat), .prn_strobe_o(pstb), .prn_busy_i(busy), .cas_data_o(cas_d), .cas_clk_o(),
        .cas_clk_i(tclk), .cas_data_i(cdi), .cas_last_i(1'b1), .cas_next_o()
    );
    tpio_partner prt (.clk_i(clk), .stb_i(pstb), .run_i(run), .busy_o(busy), .tclk_o(tclk));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [6:0] memfn(input logic [10:0] a);
        return a[6:0] ^ 7'h2a;
    endfunction : memfn
    function automatic logic [9:0] frame(input logic [6:0] d, input logic odd);
        return {1'b1, ^d ^ odd, d, 1'b0};
    endfunction : frame

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    task automatic fail_to(input string nm);
        mismatches++;
        $display("[ERR] %s expected done seen timeout", nm);
        complete_run();
    endtask : fail_to
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 64);
        if (k >= 64) fail_to("pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_stb(input logic lvl);
        k = 0;
        while (pstb !== lvl && k < 2000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 2000) fail_to("prn_strobe");
    endtask : wait_stb
    task automatic get_frame(input logic tape, input logic [9:0] exp);
        logic [9:0] f;
        sel = tape;
        k = 0;
        while (ln !== 1'b0 && k < 5000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 5000) fail_to("frame");
        if (!tape) repeat (BD / 2) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            if (tape) @(posedge tclk);
            else if (i > 0) repeat (BD) @(posedge clk);
            f[i] = ln;
        end
        chk("frame", {22'h0, f}, {22'h0, exp});
    endtask : get_frame
    task automatic send_rx(input logic [6:0] d, input logic bad);
        logic [9:0] b;
        b = frame(d, 1'b0) ^ {1'b0, bad, 8'h00};
        for (int i = 0; i < 10; i++) begin
            {rxd, cdi} <= {2{b[i]}};
            repeat (bw) @(posedge clk);
        end
        repeat (2 * bw) @(posedge clk);
    endtask : send_rx

    initial forever #12.5 clk = ~clk;
    // Memory answers the cycle after a read and shows changing data otherwise.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        mrd <= (mem.re === 1'b1) ? memfn(mem.addr) : ~mrd;
        if (mem.we === 1'b1) {wa, wd} <= {mem.addr, mem.data};
        if (trig === 1'b1) {tcmd, ntrig} <= {cmd, ntrig + 1};
    end
    initial begin
        repeat (100000) @(posedge clk);
        fail_to("run");
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("txd_idle", txd, 1);
        apb(0, `TPIO_A_BAUD, 0);
        chk("baud_rst", rd, `TPIO_BAUD_RST);
        apb(0, 8'h40, 0);
        chk("unmapped", {rd[30:0], err}, 1);
        apb(1, `TPIO_A_BAUD, BD);
        $display("registers done");
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            apb(1, `TPIO_A_CTRL, {29'h0, seed[8], 1'b0, seed[9]});
            kb_char <= seed[6:0];
            kb_stb <= 1'b1;
            @(posedge clk);
            kb_stb <= 1'b0;
            get_frame(1'b0, frame(seed[6:0], seed[8]));
        end
        apb(1, `TPIO_A_XFER, {5'h0, 11'd2, 5'h0, 11'd5});
        apb(1, `TPIO_A_CTRL, 32'h102);
        for (int i = 5; i < 7; i++) get_frame(1'b0, frame(memfn(11'(i)), 1'b0));
        $display("host send done");
        apb(1, `TPIO_A_XFER, {5'h0, 11'd3, 5'h0, 11'd9});
        apb(1, `TPIO_A_CTRL, 32'h200);
        for (int i = 9; i < 12; i++) begin
            wait_stb(1'b1);
            chk("prn_data", pdat, memfn(11'(i)));
            chk("prn_busy", busy, 0);
            if (i > 9) chk("prn_pace", cyc - last >= 200, 1);
            last = cyc;
            wait_stb(1'b0);
        end
        $display("printer done");
        apb(1, `TPIO_A_CTRL, 32'h0);
        n0 = ntrig;
        send_rx(7'h05, 1'b0);
        chk("ctl_cmd", tcmd, 5'h05);
        send_rx(7'h11, 1'b0);
        send_rx(7'h03, 1'b0);
        send_rx(7'h02, 1'b0);
        chk("cursor", {cx, cy, tcmd}, {7'h03, 5'h02, 5'h11});
        chk("trig_cnt", ntrig - n0, 2);
        seed = lfsr(seed);
        c = 7'h20 + seed[5:0];
        send_rx(c, 1'b0);
        chk("rx_write", {wa, wd, cx}, {11'd151, c, 7'h04});
        send_rx(7'h41, 1'b1);
        apb(0, `TPIO_A_STAT, 0);
        chk("perr", rd[0], 1);
        apb(1, `TPIO_A_STAT, 1);
        apb(0, `TPIO_A_STAT, 0);
        chk("perr_clr", rd[0], 0);
        $display("host receive done");
        apb(1, `TPIO_A_XFER, {5'h0, 11'd2, 5'h0, 11'd30});
        apb(1, `TPIO_A_CTRL, 32'h10);
        bw = 20;
        n0 = ntrig;
        seed = lfsr(seed);
        send_rx(seed[6:0], 1'b0);
        send_rx(seed[13:7], 1'b0);
        chk("page_wr", {wa, wd}, {11'd31, seed[13:7]});
        chk("page_trig", ntrig - n0, 2);
        $display("page play done");
        run <= 1'b1;
        apb(1, `TPIO_A_XFER, {5'h0, 11'd1, 5'h0, 11'd20});
        apb(1, `TPIO_A_CTRL, 32'h408);
        get_frame(1'b1, frame(memfn(11'd20), 1'b0));
        run <= 1'b0;
        $display("record done");
        complete_run();
    end
endmodule : tpio_top_tb
